// ---- rpc_pkg.sv ----
// Overview of operation
// - the packet checksum begins at the byte offset in checksum_start_offset, zero meaning the first byte, reset zero.
// - with ip_payload_checksum_adjust clear the reported value is the raw 16-bit ones-complement sum of covered bytes.
// - with vlan_strip_enable set, offset counting and summing run on the frame after the vlan tag is removed.
// - with strip_crc set the trailing four frame check sequence bytes are kept out of the sum.
// - with checksum_report_disable clear the checksum is written to the descriptor in the receive_hash_field slot.
// - three independent offloads exist: packet checksum, ip header check and tcp/udp check; the ip and tcp/udp checks are only enable outputs here.
package rpc_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [15:0] RPC_CSUM_CTRL_OFS = 16'h5000;
    localparam logic [15:0] RPC_RX_CTRL_OFS = 16'h5004;
    localparam logic [15:0] RPC_STATUS_OFS = 16'h5008;
    localparam logic [31:0] RPC_CSUM_CTRL_RST = 32'h0000_0000;
    localparam int RPC_START_LSB = 0;
    localparam int RPC_ADJUST_BIT = 12;
    localparam int RPC_REPORT_DIS_BIT = 13;
    localparam int RPC_IP_OFLD_BIT = 8;
    localparam int RPC_TU_OFLD_BIT = 9;
    localparam int RPC_RXON_BIT = 0;
    localparam int RPC_VLAN_BIT = 1;
    localparam int RPC_STRIP_BIT = 2;
    localparam logic [3:0] RPC_CRC_BYTES = 4'h4;
    localparam logic [3:0] RPC_VLAN_POS = 4'hc;
    localparam logic [3:0] RPC_VLAN_LEN = 4'h4;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } rpc_byte_s;

    typedef struct packed {
        logic [15:0] csum;
        logic report;
    } rpc_desc_s;
endpackage

// ---- rpc_fifo.sv ----
`timescale 1ns/1ps
module rpc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
        $error("depth must be a power of two");
    end
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
        logic room;
    } rpc_fifo_s;
    rpc_fifo_s st_q, st_d;
    logic empty;
    // ----------------------------------------
    // pointers
    // ----------------------------------------
    assign empty = st_q.wp == st_q.rp;
    assign in_ready = st_q.room; // registered, so the port comes from a flop
    assign out_valid = !empty;
    assign out_data = st_q.mem[st_q.rp[AW-1:0]];
    // push and pop
    always_comb begin
        st_d = st_q;
        if (in_valid && st_q.room) begin
            st_d.mem[st_q.wp[AW-1:0]] = in_data;
            st_d.wp = st_q.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            st_d.rp = st_q.rp + 1'b1;
        end
        // room follows the next pointers, exact after a push and a pop together
        st_d.room = !((st_d.wp[AW] != st_d.rp[AW]) && (st_d.wp[AW-1:0] == st_d.rp[AW-1:0]));
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end
endmodule // rpc_fifo

// ---- rpc_top.sv ----
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module rpc_top #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    output logic desc_valid,
    output logic [15:0] receive_hash_field,
    output logic desc_csum_reported,
    output logic ip_check_en,
    output logic tu_check_en
);
    if (FIFO_DEPTH < 2) begin : g_depth_check
        $error("fifo depth too small");
    end
    typedef enum logic [1:0] {
        RPC_IDLE = 2'b00,
        RPC_RUN = 2'b01,
        RPC_DONE = 2'b11
    } rpc_state_e;
    typedef struct packed {
        logic [31:0] ctrl;
        logic rx_on;
        logic vlan_on;
        logic strip_on;
        logic wr_pend;
        logic [15:0] wr_addr;
        logic [31:0] rdata;
        rpc_state_e fsm;
        logic [15:0] pos;
        logic [16:0] sum;
        logic odd;
        logic [7:0] hi;
        logic [3:0][7:0] tail;
        logic [2:0] tail_n;
        logic dv;
        logic [15:0] dsum;
        logic drep;
        logic [31:0] frames;
    } rpc_top_s;
    rpc_top_s st_q, st_d;
    rpc_pkg::rpc_byte_s fin, fout;
    logic f_valid, f_ready;
    // ----------------------------------------
    // input fifo
    // ----------------------------------------
    assign fin.data = rx_data;
    assign fin.last = rx_last;
    rpc_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .in_valid(rx_valid),
        .in_ready(rx_ready),
        .in_data(fin),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(fout)
    );
    // stall draining while the last result is still pending
    assign f_ready = (st_q.fsm != RPC_DONE);

    // one's complement add of a word with end-around carry
    function automatic logic [16:0] oc_add(input logic [16:0] s, input logic [15:0] w);
        logic [16:0] t;
        t = {1'b0, s[15:0]} + {1'b0, w};
        oc_add = {1'b0, t[15:0]} + {16'h0000, t[16]};
        return {1'b0, oc_add[15:0]};
    endfunction

    // is this byte address one of our registers
    function automatic logic hit(input logic [15:0] a);
        hit = (a == rpc_pkg::RPC_CSUM_CTRL_OFS) || (a == rpc_pkg::RPC_RX_CTRL_OFS)
            || (a == rpc_pkg::RPC_STATUS_OFS);
    endfunction

    logic [7:0] start_ofs;
    logic skip_vlan, covered, in_tail_mode;
    logic [7:0] b_out;
    logic b_emit;
    assign start_ofs = st_q.ctrl[rpc_pkg::RPC_START_LSB +: 8];
    assign in_tail_mode = st_q.strip_on;

    always_comb begin
        st_d = st_q;
        skip_vlan = 1'b0;
        covered = 1'b0;
        b_out = 8'h00;
        b_emit = 1'b0;
        // ----------------------------------------
        // ahb-lite slave, zero wait states
        // ----------------------------------------
        if (st_q.wr_pend) begin
            if (st_q.wr_addr == rpc_pkg::RPC_CSUM_CTRL_OFS) begin
                st_d.ctrl = hwdata;
            end else if (st_q.wr_addr == rpc_pkg::RPC_RX_CTRL_OFS) begin
                st_d.rx_on = hwdata[rpc_pkg::RPC_RXON_BIT];
                st_d.vlan_on = hwdata[rpc_pkg::RPC_VLAN_BIT];
                st_d.strip_on = hwdata[rpc_pkg::RPC_STRIP_BIT];
            end
        end
        st_d.wr_pend = 1'b0;
        if (hsel && hready && htrans[1]) begin
            st_d.wr_pend = hwrite && hit(haddr[15:0]);
            st_d.wr_addr = haddr[15:0];
        end
        // read data moves only on a read, so it stands until the next one
        if (hsel && hready && htrans[1] && !hwrite) begin
            case (haddr[15:0])
                rpc_pkg::RPC_CSUM_CTRL_OFS: begin
                    st_d.rdata = st_q.ctrl;
                end
                rpc_pkg::RPC_RX_CTRL_OFS: begin
                    st_d.rdata = {29'h0, st_q.strip_on, st_q.vlan_on, st_q.rx_on};
                end
                rpc_pkg::RPC_STATUS_OFS: begin
                    st_d.rdata = st_q.frames;
                end
                default: begin
                    st_d.rdata = 32'h0000_0000;
                end
            endcase
        end
        // ----------------------------------------
        // byte stream: position, vlan skip, coverage
        // ----------------------------------------
        st_d.dv = 1'b0;
        if (st_q.fsm == RPC_DONE) begin
            st_d.fsm = RPC_IDLE;
        end
        if (f_valid && f_ready) begin
            // the tag's 4 bytes vanish from the frame when stripping
            skip_vlan = st_q.vlan_on && (st_q.pos >= {12'h000, rpc_pkg::RPC_VLAN_POS})
                && (st_q.pos < {12'h000, rpc_pkg::RPC_VLAN_POS} + {12'h000, rpc_pkg::RPC_VLAN_LEN});
            st_d.pos = st_q.pos + 16'h0001;
            st_d.fsm = RPC_RUN;
            if (!skip_vlan) begin
                // offset counted after tag removal
                covered = ((st_q.pos - (st_q.vlan_on && st_q.pos >= {12'h000, rpc_pkg::RPC_VLAN_POS}
                    ? {12'h000, rpc_pkg::RPC_VLAN_LEN} : 16'h0000)) >= {8'h00, start_ofs});
            end
            // delay line keeps crc bytes out until we know they are not last
            if (covered && in_tail_mode) begin
                st_d.tail = {st_q.tail[2:0], fout.data};
                if (st_q.tail_n == 3'd4) begin
                    b_out = st_q.tail[3];
                    b_emit = 1'b1;
                end else begin
                    st_d.tail_n = st_q.tail_n + 3'd1;
                end
            end else if (covered) begin
                b_out = fout.data;
                b_emit = 1'b1;
            end
        end
        // big-endian word pairing
        if (b_emit) begin
            if (st_q.odd) begin
                st_d.sum = oc_add(st_q.sum, {st_q.hi, b_out});
                st_d.odd = 1'b0;
            end else begin
                st_d.hi = b_out;
                st_d.odd = 1'b1;
            end
        end
        // ----------------------------------------
        // end of frame: pad, report
        // ----------------------------------------
        if (f_valid && f_ready && fout.last) begin
            // raw sum is reported, no adjustment hardware; slot zero when reporting is off
            if (st_q.ctrl[rpc_pkg::RPC_REPORT_DIS_BIT]) begin
                st_d.dsum = 16'h0000;
            end else begin
                st_d.dsum = 16'(st_d.odd ? oc_add(st_d.sum, {st_d.hi, 8'h00}) : st_d.sum);
            end
            st_d.drep = !st_q.ctrl[rpc_pkg::RPC_REPORT_DIS_BIT];
            st_d.dv = 1'b1;
            st_d.fsm = RPC_DONE;
            st_d.pos = 16'h0000;
            st_d.sum = 17'h00000;
            st_d.odd = 1'b0;
            st_d.tail_n = 3'd0;
            st_d.frames = st_q.frames + 32'h0000_0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
            st_q.ctrl <= rpc_pkg::RPC_CSUM_CTRL_RST;
        end else if (ce) begin
            st_q <= st_d;
        end
    end
    // ----------------------------------------
    // outputs, all from flops except hreadyout and hresp, which are tied constants
    // ----------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_q.rdata;
    assign desc_valid = st_q.dv;
    assign receive_hash_field = st_q.dsum;
    assign desc_csum_reported = st_q.drep;
    // the other two offloads are independent, enables only
    assign ip_check_en = st_q.ctrl[rpc_pkg::RPC_IP_OFLD_BIT];
    assign tu_check_en = st_q.ctrl[rpc_pkg::RPC_TU_OFLD_BIT];
endmodule // rpc_top

// ---- rpc_assertions.sv ----
`timescale 1ns/1ps
module rpc_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic rx_last,
    input wire logic desc_valid,
    input wire logic [15:0] receive_hash_field,
    input wire logic desc_csum_reported,
    input wire logic ip_check_en,
    input wire logic tu_check_en
);
    // ----------------------------------------
    // bus and frame sequences
    // ----------------------------------------
    logic [1:0] ofld_w;
    assign ofld_w = hwdata[9:8]; // offload enables in write data
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_ctrl_wr;
        hsel && hready && htrans[1] && hwrite && haddr == 32'h0000_5000;
    endsequence
    sequence s_read;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence s_frame_end;
        rx_valid && rx_ready && rx_last;
    endsequence
    a_resp_okay: assert property (hresp == 1'b0) else $error("error response seen");
    a_ready_high: assert property (hreadyout == 1'b1) else $error("wait state seen");
    a_offload_bits: assert property (s_ctrl_wr |=> ##1 {tu_check_en, ip_check_en} == $past(ofld_w))
        else $error("offload enables differ from written control");
    a_unmapped_read: assert property (s_read ##0 haddr == 32'h0000_5100 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (not s_read |=> $stable(hrdata)) else $error("read data moved");
    a_desc_pulse: assert property (desc_valid |=> !desc_valid) else $error("descriptor strobe too long");
    a_hash_holds: assert property (!desc_valid |-> $stable(receive_hash_field))
        else $error("checksum slot moved between frames");
    a_report_off: assert property (desc_valid && !desc_csum_reported |-> receive_hash_field == 16'h0)
        else $error("checksum written while reporting off");
    a_desc_due: assert property (s_frame_end |-> ##[2:80] desc_valid)
        else $error("no descriptor after frame end");
endmodule // rpc_checker

bind rpc_top rpc_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .rx_valid, .rx_ready, .rx_last, .desc_valid, .receive_hash_field,
    .desc_csum_reported, .ip_check_en, .tu_check_en);

// ---- rpc_frame_src.sv ----
`timescale 1ns/1ps
module rpc_frame_src (
    input wire logic hclk,
    input wire logic rx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last
);
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
    end
    // one frame; each byte held until taken, slow mode idles between bytes
    task automatic send(input logic [7:0] q[$], input logic slow, output logic stuck);
        stuck = 1'b0;
        for (int i = 0; i < q.size(); i++) begin
            rx_valid <= 1'b1;
            rx_data <= q[i];
            rx_last <= (i == q.size() - 1);
            for (int w = 0; w < 1000; w++) begin
                @(negedge hclk);
                if (rx_ready) break;
                @(posedge hclk);
            end
            stuck = stuck || !rx_ready; // a byte that was never taken
            @(posedge hclk);
            if (slow || i == q.size() - 1) begin
                rx_valid <= 1'b0;
                rx_data <= ~q[i]; // idle data is junk, never the last byte
                rx_last <= 1'b0;
                if (slow) @(posedge hclk);
            end
        end
    endtask
endmodule // rpc_frame_src

// ---- rpc_top_test.sv ----
`timescale 1ns/1ps
module rpc_top_test;
    logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp, rx_valid, rx_ready, rx_last;
    logic desc_valid, desc_csum_reported, ip_check_en, tu_check_en, stuck;
    logic [31:0] haddr, hwdata, hrdata, rd, r, ctl;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] rx_data;
    logic [15:0] receive_hash_field;
    logic [7:0] fr[$];
    logic [31:0] seed = 32'h463c;
    int mismatches = 0, tests_run = 0, len, adj;
    assign hready = hreadyout;
    rpc_top u_dut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .rx_valid, .rx_ready, .rx_data, .rx_last, .desc_valid,
        .receive_hash_field, .desc_csum_reported, .ip_check_en, .tu_check_en);
    rpc_frame_src u_src (.hclk, .rx_ready, .rx_valid, .rx_data, .rx_last);
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // reference sum: tag removed first, then crc, then offset; odd byte padded
    // stop cuts the sum short, for the head that software backs out
    function automatic logic [15:0] model(logic [7:0] f[$], int st, bit vl, bit sc, int stop = 32'h1000);
        logic [7:0] b[$];
        int s;
        int n;
        if (vl) b = {f[0:11], f[16:$]};
        else b = f;
        if (sc) b = b[0:$-4];
        n = (stop < b.size()) ? stop : b.size();
        s = 0;
        for (int i = st; i < n; i += 2) begin
            s += {b[i], (i + 1 < n) ? b[i + 1] : 8'h00};
            s = (s & 32'hffff) + (s >> 16); // end-around carry
        end
        return 16'(s);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            mismatches++;
        end
    endtask
    task automatic conclude();
        if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // single ahb transfer; waits are bounded but ready is always honoured
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        int w;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        w = 0;
        do @(posedge hclk); while (!hready && ++w < 100);
        if (hready !== 1'b1) begin
            mismatches++;
            conclude();
        end
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (!hready && ++w < 200);
        if (hready !== 1'b1) begin
            mismatches++;
            conclude();
        end
        q = hrdata;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {hresetn, hsel, hwrite} = '0;
        {haddr, hwdata, htrans} = '0;
        ce = 1'b1;
        hsize = 3'h2;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, 32'h5000, 32'h0, rd);
        chk(rd, rpc_pkg::RPC_CSUM_CTRL_RST);
        ahb(1'b1, 32'h5100, 32'hffff_ffff, rd);
        ahb(1'b0, 32'h5100, 32'h0, rd);
        chk(rd, 32'h0);
        // buffer empty after reset, so bytes are accepted; no frame counted yet
        chk(32'(rx_ready), 32'h1);
        ahb(1'b0, 32'h5008, 32'h0, rd);
        chk(rd, 32'h0);
        for (int k = 0; k < 24; k++) begin
            r = xs();
            ctl = r & 32'h0000_3300;
            ctl[7:0] = (k < 2) ? {8{k[0]}} : 8'(r[23:16] % 48);
            ahb(1'b1, 32'h5004, 32'h0, rd);
            ahb(1'b1, 32'h5000, ctl, rd);
            ahb(1'b0, 32'h5000, 32'h0, rd);
            chk(rd, ctl);
            ahb(1'b1, 32'h5004, {29'h0, k[1], k[0], 1'b1}, rd);
            len = 18 + int'(xs() % 40);
            fr = {};
            repeat (len) fr.push_back(8'(xs()));
            u_src.send(fr, r[4], stuck);
            for (int w = 0; w < 300 && desc_valid !== 1'b1; w++) @(negedge hclk);
            if (stuck || desc_valid !== 1'b1) begin
                mismatches++;
                conclude();
            end
            chk(32'(desc_csum_reported), 32'(!ctl[13]));
            chk(32'(receive_hash_field), ctl[13] ? 32'h0 : 32'(model(fr, ctl[7:0], k[0], k[1])));
            chk(32'({tu_check_en, ip_check_en}), 32'(ctl[9:8]));
            if (!ctl[13] && !ctl[0]) begin
                // software view: the skipped head added back gives the whole-frame sum
                adj = int'(receive_hash_field) + int'(model(fr, 0, k[0], k[1], ctl[7:0]));
                chk((adj & 32'hffff) + (adj >> 16), 32'(model(fr, 0, k[0], k[1])));
            end
            @(posedge hclk);
        end
        ahb(1'b0, 32'h5008, 32'h0, rd);
        chk(rd, 32'h18);
        conclude();
    end
endmodule // rpc_top_test
